// File: common/rtac_pkg.sv
/*
 * Shared constants and types of the alarm-match and timer-control block.
 * Assumes an 8-bit register port and a calendar whose counters are BCD coded.
 */
`default_nettype none

package rtac_pkg;

	localparam int RTAC_NUM_ALM = 5;
	localparam int RTAC_ALM_EN_BIT = 7;

	// Alarm entries in order: second, minute, hour, day of month, day of week.
	localparam int RTAC_IDX_SEC = 0;
	localparam int RTAC_IDX_MIN = 1;
	localparam int RTAC_IDX_HR = 2;
	localparam int RTAC_IDX_DOM = 3;
	localparam int RTAC_IDX_DOW = 4;

	localparam logic [7:0] RTAC_OFS_SEC_ALM = 8'h0A;
	localparam logic [7:0] RTAC_OFS_MIN_ALM = 8'h0B;
	localparam logic [7:0] RTAC_OFS_HR_ALM = 8'h0C;
	localparam logic [7:0] RTAC_OFS_DOM_ALM = 8'h0D;
	localparam logic [7:0] RTAC_OFS_DOW_ALM = 8'h0E;
	localparam logic [7:0] RTAC_OFS_TMR_CTL = 8'h10;

	localparam logic [RTAC_NUM_ALM-1:0][7:0] RTAC_ALM_OFS = {
		RTAC_OFS_DOW_ALM, RTAC_OFS_DOM_ALM, RTAC_OFS_HR_ALM, RTAC_OFS_MIN_ALM, RTAC_OFS_SEC_ALM};

	// Bits that exist in each alarm register; all others are fixed at zero.
	localparam logic [7:0] RTAC_MASK_SEC = 8'hFF;
	localparam logic [7:0] RTAC_MASK_MIN = 8'hFF;
	localparam logic [7:0] RTAC_MASK_HR = 8'hBF;
	localparam logic [7:0] RTAC_MASK_DOM = 8'hBF;
	localparam logic [7:0] RTAC_MASK_DOW = 8'h87;
	localparam logic [RTAC_NUM_ALM-1:0][7:0] RTAC_ALM_MASK = {
		RTAC_MASK_DOW, RTAC_MASK_DOM, RTAC_MASK_HR, RTAC_MASK_MIN, RTAC_MASK_SEC};

	// Reset leaves every alarm field disabled with a zero target.
	localparam logic [7:0] RTAC_ALM_RST = 8'h80;

	localparam int RTAC_TMR_MODE_HI = 7;
	localparam int RTAC_TMR_MODE_LO = 6;
	localparam int RTAC_TMR_PULSE_BIT = 5;
	localparam int RTAC_TMR_TICK_HI = 1;
	localparam int RTAC_TMR_TICK_LO = 0;
	localparam logic [7:0] RTAC_TMR_MASK = 8'hE3;
	localparam logic [7:0] RTAC_TMR_RST = 8'h03;

	localparam logic [1:0] RTAC_MODE_OFF = 2'h0;
	localparam logic [1:0] RTAC_MODE_CD = 2'h1;
	localparam logic [1:0] RTAC_MODE_WD_IRQ = 2'h2;
	localparam logic [1:0] RTAC_MODE_WD_RST = 2'h3;

	localparam logic [1:0] RTAC_TICK_4096HZ = 2'h0;
	localparam logic [1:0] RTAC_TICK_64HZ = 2'h1;
	localparam logic [1:0] RTAC_TICK_1HZ = 2'h2;
	localparam logic [1:0] RTAC_TICK_1PM = 2'h3;

	typedef struct packed {
		logic [6:0] sec;
		logic [6:0] min;
		logic [5:0] hour;
		logic [5:0] dom;
		logic [2:0] dow;
	} rtac_cal_type;

	typedef struct packed {
		logic [1:0] timer_mode_select;
		logic       irq_pulse_select;
		logic [1:0] tick_source_select;
	} rtac_tmr_type;

endpackage

`default_nettype wire

// File: rtl/rtac_match.sv
/*
 * Combinational comparison of the five alarm targets with the running calendar.
 * Assumes the calendar fields are BCD and stable whenever the update tick is seen.
 */
`timescale 1ns/1ps
`default_nettype none

module rtac_match
	import rtac_pkg::*;
(
	input  wire logic [RTAC_NUM_ALM-1:0][7:0] alm,
	input  wire rtac_cal_type                 cal,
	output logic                              match
);

	logic [RTAC_NUM_ALM-1:0] field_eq;
	logic [RTAC_NUM_ALM-1:0] field_ok;
	logic [RTAC_NUM_ALM-1:0] field_off;

	assign field_eq[RTAC_IDX_SEC] = alm[RTAC_IDX_SEC][6:0] == cal.sec;
	assign field_eq[RTAC_IDX_MIN] = alm[RTAC_IDX_MIN][6:0] == cal.min;
	// In both hour modes the six low bits carry the whole encoding, so one compare serves.
	assign field_eq[RTAC_IDX_HR] = alm[RTAC_IDX_HR][5:0] == cal.hour;
	assign field_eq[RTAC_IDX_DOM] = alm[RTAC_IDX_DOM][5:0] == cal.dom;
	assign field_eq[RTAC_IDX_DOW] = alm[RTAC_IDX_DOW][2:0] == cal.dow;

	genvar gi;
	generate
		for (gi = 0; gi < RTAC_NUM_ALM; gi++) begin : g_field
			assign field_off[gi] = alm[gi][RTAC_ALM_EN_BIT];
			assign field_ok[gi] = field_off[gi] | field_eq[gi];
		end
	endgenerate

	// An alarm with every field disabled never matches.
	assign match = (&field_ok) & ~(&field_off);

endmodule

`default_nettype wire

// File: rtl/rtac_top.sv
/*
 * Alarm registers with match flag, and timer-control register that steers the
 * interrupt and reset pin drivers of a real-time clock.
 * Assumes a synchronous byte-wide register port, a calendar that presents its
 * counters with a one-cycle tick after each update, and external timer logic
 * that supplies the periodic, countdown and watchdog flags.
 */
`timescale 1ns/1ps
`default_nettype none

module rtac_top
	import rtac_pkg::*;
(
	input  wire logic         SYS_CLK,
	input  wire logic         RST_B,
	input  wire logic [7:0]   REG_ADDR,
	input  wire logic [7:0]   REG_WDATA,
	input  wire logic         REG_WR,
	input  wire logic         REG_RD,
	output logic [7:0]        REG_RDATA,
	input  wire rtac_cal_type CAL,
	input  wire logic         CAL_TICK,
	input  wire logic         ALARM_CLR,
	output logic              ALARM_FLAG,
	input  wire logic         PERIODIC_FLAG,
	input  wire logic         COUNTDOWN_FLAG,
	input  wire logic         COUNTDOWN_IRQ_EN,
	input  wire logic         WATCHDOG_FLAG,
	output rtac_tmr_type      TMR_CFG,
	output logic              COUNTDOWN_RUN,
	output logic              WATCHDOG_RUN,
	output logic              IRQ_ACTIVE,
	output logic              RST_PIN_ACTIVE
);

	logic [7:0] alm_r [RTAC_NUM_ALM];
	logic [7:0] alm_nxt [RTAC_NUM_ALM];
	logic [RTAC_NUM_ALM-1:0][7:0] alm_flat;
	logic [RTAC_NUM_ALM-1:0] alm_hit;
	logic [RTAC_NUM_ALM-1:0][7:0] rd_part;
	logic [7:0] tmr_r;
	logic [7:0] tmr_nxt;
	logic       tmr_hit;
	logic [7:0] rd_word;
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;

	// Register decode and write masking.
	genvar gi;
	generate
		for (gi = 0; gi < RTAC_NUM_ALM; gi++) begin : g_alm
			assign alm_hit[gi] = REG_ADDR == RTAC_ALM_OFS[gi];
			// Unused bits are forced low here so they neither store nor read back.
			assign alm_nxt[gi] = (REG_WR && alm_hit[gi]) ? (REG_WDATA & RTAC_ALM_MASK[gi]) :
				alm_r[gi];
			assign alm_flat[gi] = alm_r[gi];
			assign rd_part[gi] = alm_hit[gi] ? alm_r[gi] : 8'h00;
		end
	endgenerate

	assign tmr_hit = REG_ADDR == RTAC_OFS_TMR_CTL;
	assign tmr_nxt = (REG_WR && tmr_hit) ? (REG_WDATA & RTAC_TMR_MASK) : tmr_r;

	// Unmapped addresses read as zero.
	assign rd_word = rd_part[RTAC_IDX_SEC] | rd_part[RTAC_IDX_MIN] | rd_part[RTAC_IDX_HR] |
		rd_part[RTAC_IDX_DOM] | rd_part[RTAC_IDX_DOW] | (tmr_hit ? tmr_r : 8'h00);
	assign rdata_nxt = REG_RD ? rd_word : rdata_r;

	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			for (int i = 0; i < RTAC_NUM_ALM; i++) begin
				alm_r[i] <= RTAC_ALM_RST;
			end
			tmr_r <= RTAC_TMR_RST;
			rdata_r <= 8'h00;
		end else begin
			for (int i = 0; i < RTAC_NUM_ALM; i++) begin
				alm_r[i] <= alm_nxt[i];
			end
			tmr_r <= tmr_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign REG_RDATA = rdata_r;

	// Timer configuration fields.
	logic [1:0] timer_mode_select;
	logic       irq_pulse_select;
	logic [1:0] tick_source_select;

	assign timer_mode_select = tmr_r[RTAC_TMR_MODE_HI:RTAC_TMR_MODE_LO];
	assign irq_pulse_select = tmr_r[RTAC_TMR_PULSE_BIT];
	assign tick_source_select = tmr_r[RTAC_TMR_TICK_HI:RTAC_TMR_TICK_LO];

	assign TMR_CFG.timer_mode_select = timer_mode_select;
	assign TMR_CFG.irq_pulse_select = irq_pulse_select;
	assign TMR_CFG.tick_source_select = tick_source_select;

	// Watchdog owns the timer in both of its modes, so countdown is unavailable there.
	assign COUNTDOWN_RUN = timer_mode_select == RTAC_MODE_CD;
	assign WATCHDOG_RUN = timer_mode_select[1];

	// Alarm match and flag.
	logic match_now;
	logic match_r;
	logic match_nxt;
	logic alarm_set;
	logic alarm_flag_r;
	logic alarm_flag_nxt;

	rtac_match u_match (
		.alm   (alm_flat),
		.cal   (CAL),
		.match (match_now)
	);

	// Sampling only on the tick keeps a lasting match from setting the flag again.
	assign match_nxt = CAL_TICK ? match_now : match_r;
	assign alarm_set = CAL_TICK && match_now && !match_r;
	// A set in the cycle of a clear wins, so no alarm is lost.
	assign alarm_flag_nxt = alarm_set | (alarm_flag_r & ~ALARM_CLR);

	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			match_r <= 1'b0;
			alarm_flag_r <= 1'b0;
		end else begin
			match_r <= match_nxt;
			alarm_flag_r <= alarm_flag_nxt;
		end
	end

	assign ALARM_FLAG = alarm_flag_r;

	// Interrupt and reset pin drivers.
	logic cd_src;
	logic wd_irq;
	logic wd_rst;
	logic per_prev_r;
	logic cd_prev_r;
	logic irq_edge;
	logic irq_level;
	logic irq_r;
	logic irq_nxt;
	logic rst_r;
	logic rst_nxt;

	assign cd_src = COUNTDOWN_FLAG && COUNTDOWN_IRQ_EN && (timer_mode_select == RTAC_MODE_CD);
	assign wd_irq = WATCHDOG_FLAG && (timer_mode_select == RTAC_MODE_WD_IRQ);
	assign wd_rst = WATCHDOG_FLAG && (timer_mode_select == RTAC_MODE_WD_RST);
	assign irq_level = PERIODIC_FLAG | cd_src;
	assign irq_edge = (PERIODIC_FLAG & ~per_prev_r) | (cd_src & ~cd_prev_r);
	// The pulse is one clock long; the watchdog interrupt is always a held level.
	assign irq_nxt = (irq_pulse_select ? irq_edge : irq_level) | wd_irq;
	assign rst_nxt = wd_rst;

	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			per_prev_r <= 1'b0;
			cd_prev_r <= 1'b0;
			irq_r <= 1'b0;
			rst_r <= 1'b0;
		end else begin
			per_prev_r <= PERIODIC_FLAG;
			cd_prev_r <= cd_src;
			irq_r <= irq_nxt;
			rst_r <= rst_nxt;
		end
	end

	assign IRQ_ACTIVE = irq_r;
	assign RST_PIN_ACTIVE = rst_r;

	// Checks.
	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (!RST_B);

	AST_SEC_WRITE: assert property (
		REG_WR && REG_ADDR == RTAC_OFS_SEC_ALM |=> alm_r[RTAC_IDX_SEC] == $past(REG_WDATA))
		else $error("Seconds alarm did not store the written byte.");

	AST_MIN_WRITE: assert property (
		REG_WR && REG_ADDR == RTAC_OFS_MIN_ALM |=> alm_r[RTAC_IDX_MIN] == $past(REG_WDATA))
		else $error("Minutes alarm did not store the written byte.");

	// Readback checks allow the idle cycle that a host leaves between a write and the next read.
	AST_HR_UNUSED: assert property (
		REG_WR && REG_ADDR == RTAC_OFS_HR_ALM ##1 !REG_WR ##1 REG_RD && REG_ADDR == RTAC_OFS_HR_ALM && !REG_WR
		|=> REG_RDATA[6] == 1'b0 && REG_RDATA[5:0] == $past(REG_WDATA[5:0], 3))
		else $error("Hours alarm read back wrong or unused bit not zero.");

	AST_DAY_WRITE: assert property (
		REG_WR && REG_ADDR == RTAC_OFS_DOM_ALM |=> alm_r[RTAC_IDX_DOM] == ($past(REG_WDATA) & 8'hBF))
		else $error("Day alarm masking wrong.");

	AST_DOW_READ: assert property (
		REG_RD && REG_ADDR == RTAC_OFS_DOW_ALM |=> REG_RDATA[6:3] == 4'h0)
		else $error("Weekday alarm unused bits read nonzero.");

	AST_TMR_READ: assert property (
		REG_WR && REG_ADDR == RTAC_OFS_TMR_CTL ##1 !REG_WR ##1 REG_RD && REG_ADDR == RTAC_OFS_TMR_CTL && !REG_WR
		|=> REG_RDATA == ($past(REG_WDATA, 3) & RTAC_TMR_MASK))
		else $error("Timer control read back wrong.");

	AST_ALARM_SET: assert property (
		CAL_TICK && match_now && !match_r |=> ALARM_FLAG ##1 (ALARM_FLAG || $past(ALARM_CLR)))
		else $error("Alarm flag not set on entry into a match.");

	AST_ALARM_HOLD: assert property (
		ALARM_FLAG && !ALARM_CLR |=> ALARM_FLAG)
		else $error("Alarm flag dropped without a clear.");

	AST_ALARM_QUIET: assert property (
		!ALARM_FLAG && !CAL_TICK |=> !ALARM_FLAG)
		else $error("Alarm flag set outside a calendar tick.");

	AST_ALL_OFF: assert property (
		!ALARM_FLAG && alm_r[0][7] && alm_r[1][7] && alm_r[2][7] && alm_r[3][7] && alm_r[4][7] |=> !ALARM_FLAG)
		else $error("Alarm flag set with every field disabled.");

	AST_MODE_OFF: assert property (
		timer_mode_select == RTAC_MODE_OFF |-> !COUNTDOWN_RUN && !WATCHDOG_RUN ##1 !RST_PIN_ACTIVE)
		else $error("Timer active in off mode.");

	AST_CD_GATE: assert property (
		timer_mode_select == RTAC_MODE_CD && !irq_pulse_select && COUNTDOWN_FLAG && !PERIODIC_FLAG
		|=> IRQ_ACTIVE == $past(COUNTDOWN_IRQ_EN))
		else $error("Countdown interrupt not gated by its enable.");

	AST_WD_IRQ: assert property (
		timer_mode_select == RTAC_MODE_WD_IRQ && WATCHDOG_FLAG |=> IRQ_ACTIVE && !RST_PIN_ACTIVE)
		else $error("Watchdog interrupt mode drove the wrong pin.");

	AST_WD_RST: assert property (
		timer_mode_select == RTAC_MODE_WD_RST && WATCHDOG_FLAG && !PERIODIC_FLAG |=> RST_PIN_ACTIVE && !IRQ_ACTIVE)
		else $error("Watchdog reset mode drove the wrong pin.");

	AST_LEVEL: assert property (
		!irq_pulse_select && PERIODIC_FLAG |=> IRQ_ACTIVE)
		else $error("Level interrupt not held while flag set.");

	AST_PULSE: assert property (
		irq_pulse_select && $rose(PERIODIC_FLAG) |=> IRQ_ACTIVE)
		else $error("No interrupt pulse on flag rise.");

	AST_PULSE_END: assert property (
		irq_pulse_select && timer_mode_select == RTAC_MODE_OFF && PERIODIC_FLAG && $past(PERIODIC_FLAG)
		|=> !IRQ_ACTIVE)
		else $error("Pulsed interrupt held as a level.");

	AST_ALARM_CLEAR: assert property (
		ALARM_CLR && !CAL_TICK |=> !ALARM_FLAG)
		else $error("Alarm flag not cleared by software.");

	AST_TICK_SRC: assert property (
		REG_WR && REG_ADDR == RTAC_OFS_TMR_CTL |=> TMR_CFG.tick_source_select == $past(REG_WDATA[1:0]))
		else $error("Tick source not taken from the written byte.");

	AST_MODE_WRITE: assert property (
		REG_WR && REG_ADDR == RTAC_OFS_TMR_CTL |=> TMR_CFG.timer_mode_select == $past(REG_WDATA[7:6])
		&& TMR_CFG.irq_pulse_select == $past(REG_WDATA[5]))
		else $error("Timer mode or pulse select not taken from the written byte.");

	// Entering countdown mode with the flag already up counts as the flag becoming set.
	AST_CD_PULSE: assert property (
		irq_pulse_select && !PERIODIC_FLAG && COUNTDOWN_FLAG && COUNTDOWN_IRQ_EN && $rose(COUNTDOWN_RUN)
		|=> IRQ_ACTIVE)
		else $error("No interrupt pulse when the countdown source became set.");

	AST_CD_RUN: assert property (
		timer_mode_select == RTAC_MODE_CD |-> COUNTDOWN_RUN && !WATCHDOG_RUN)
		else $error("Countdown mode did not run the countdown alone.");

	AST_WD_RUN: assert property (
		timer_mode_select[1] |-> WATCHDOG_RUN && !COUNTDOWN_RUN)
		else $error("Watchdog mode left the countdown available.");

endmodule

`default_nettype wire

// File: verification/rtac_host.sv
/*
 * Host-side model of the byte register port: one-cycle strobes, read data taken a cycle later.
 * Assumes the block samples its strobes on the rising edge of the shared clock.
 */
`timescale 1ns/1ps
`default_nettype none

module rtac_host (
	input  wire logic       clk,
	input  wire logic [7:0] rdata,
	output logic      [7:0] addr,
	output logic      [7:0] wdata,
	output logic            wr,
	output logic            rd
);
	initial begin
		addr = 8'h00;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
	end

	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		// Released data is scrambled so that a late sample never sees the old byte.
		wdata <= ~d;
	endtask

	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(posedge clk);
		d = rdata;
	endtask
endmodule

`default_nettype wire

// File: verification/test_rtc_alarm_and_timer_control.sv
/*
 * Self-checking bench of the alarm-match and timer-control block.
 * Assumes the host model drives the register port and the bench plays calendar and timers.
 */
`timescale 1ns/1ps
`default_nettype none

module test_rtc_alarm_and_timer_control
	import rtac_pkg::*;
;
	logic         sys_clk;
	logic         rst_b;
	logic [7:0]   addr;
	logic [7:0]   wdata;
	logic         wr;
	logic         rd;
	logic [7:0]   rdata;
	rtac_cal_type cal;
	logic         cal_tick;
	logic         alarm_clr;
	logic         alarm_flag;
	logic         per_flag;
	logic         cd_flag;
	logic         cd_en;
	logic         wd_flag;
	rtac_tmr_type tmr_cfg;
	logic         cd_run;
	logic         wd_run;
	logic         irq;
	logic         rst_pin;
	int           mismatches;
	int           n_compared;
	logic [7:0]   fill_exp [5] = '{8'hFF, 8'hFF, 8'hBF, 8'hBF, 8'h87};

	rtac_top u_rtac_top (.SYS_CLK(sys_clk), .RST_B(rst_b), .REG_ADDR(addr), .REG_WDATA(wdata),
		.REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .CAL(cal), .CAL_TICK(cal_tick),
		.ALARM_CLR(alarm_clr), .ALARM_FLAG(alarm_flag), .PERIODIC_FLAG(per_flag),
		.COUNTDOWN_FLAG(cd_flag), .COUNTDOWN_IRQ_EN(cd_en), .WATCHDOG_FLAG(wd_flag),
		.TMR_CFG(tmr_cfg), .COUNTDOWN_RUN(cd_run), .WATCHDOG_RUN(wd_run),
		.IRQ_ACTIVE(irq), .RST_PIN_ACTIVE(rst_pin));

	rtac_host u_rtac_host (.clk(sys_clk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));

	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		u_rtac_host.rd_reg(a, d);
		check(what, exp, d);
	endtask

	task automatic tick(input rtac_cal_type c);
		@(posedge sys_clk);
		cal <= c;
		cal_tick <= 1'b1;
		@(posedge sys_clk);
		cal_tick <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic clear_alarm;
		@(posedge sys_clk);
		alarm_clr <= 1'b1;
		@(posedge sys_clk);
		alarm_clr <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic wrap_up;
		if (mismatches == 0 && n_compared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// The whole sequence needs well under a thousand cycles; this span leaves ample margin.
	initial begin
		#100000;
		mismatches++;
		wrap_up();
	end

	initial begin
		rst_b = 1'b0;
		cal = '0;
		cal_tick = 1'b0;
		alarm_clr = 1'b0;
		per_flag = 1'b0;
		cd_flag = 1'b0;
		cd_en = 1'b0;
		wd_flag = 1'b0;
		mismatches = 0;
		n_compared = 0;
		repeat (20) @(posedge sys_clk);
		rst_b <= 1'b1;
		check("flag at reset", 8'h00, {7'h0, alarm_flag});
		for (int i = 0; i < 5; i++) begin
			rchk("alarm reset", 8'h0A + i[7:0], 8'h80);
			u_rtac_host.wr_reg(8'h0A + i[7:0], 8'hFF);
			rchk("alarm fill", 8'h0A + i[7:0], fill_exp[i]);
			u_rtac_host.wr_reg(8'h0A + i[7:0], 8'h80);
		end
		rchk("timer ctl reset", 8'h10, 8'h03);
		u_rtac_host.wr_reg(8'h0F, 8'h55);
		rchk("unmapped", 8'h0F, 8'h00);
		cd_flag <= 1'b1;
		wd_flag <= 1'b1;
		cd_en <= 1'b1;
		for (int m = 0; m < 4; m++) begin
			u_rtac_host.wr_reg(8'h10, {m[1:0], 4'hF, m[1:0]});
			rchk("timer ctl", 8'h10, {m[1:0], 4'h8, m[1:0]});
			check("config", {3'h0, m[1:0], 1'b1, m[1:0]}, {3'h0, tmr_cfg});
			check("run", {6'h0, m == 1, m > 1}, {6'h0, cd_run, wd_run});
			// Pulse mode is selected here, so the countdown pulse on entering mode 01 has passed.
			check("pins", {6'h0, m == 2, m == 3}, {6'h0, irq, rst_pin});
		end
		cd_en <= 1'b0;
		u_rtac_host.wr_reg(8'h10, 8'h40);
		repeat (2) @(posedge sys_clk);
		check("countdown gated", 8'h00, {6'h0, irq, rst_pin});
		cd_en <= 1'b1;
		repeat (2) @(posedge sys_clk);
		check("countdown level", 8'h02, {6'h0, irq, rst_pin});
		u_rtac_host.wr_reg(8'h10, 8'h03);
		per_flag <= 1'b1;
		repeat (4) @(posedge sys_clk);
		check("level irq", 8'h01, {7'h0, irq});
		per_flag <= 1'b0;
		repeat (2) @(posedge sys_clk);
		check("level irq off", 8'h00, {7'h0, irq});
		u_rtac_host.wr_reg(8'h10, 8'h23);
		@(posedge sys_clk);
		per_flag <= 1'b1;
		// Sampled mid-cycle so the one-cycle pulse is seen while it stands.
		@(negedge sys_clk);
		@(negedge sys_clk);
		check("pulse on", 8'h01, {7'h0, irq});
		@(negedge sys_clk);
		check("pulse off", 8'h00, {7'h0, irq});
		tick('{sec: 7'h30, min: 7'h12, hour: 6'h25, dom: 6'h01, dow: 3'h2});
		check("all disabled", 8'h00, {7'h0, alarm_flag});
		u_rtac_host.wr_reg(8'h0A, 8'h30);
		u_rtac_host.wr_reg(8'h0C, 8'h25);
		tick('{sec: 7'h30, min: 7'h12, hour: 6'h25, dom: 6'h01, dow: 3'h2});
		check("alarm set", 8'h01, {7'h0, alarm_flag});
		tick('{sec: 7'h30, min: 7'h12, hour: 6'h25, dom: 6'h01, dow: 3'h2});
		check("alarm held", 8'h01, {7'h0, alarm_flag});
		clear_alarm();
		check("alarm cleared", 8'h00, {7'h0, alarm_flag});
		tick('{sec: 7'h30, min: 7'h12, hour: 6'h25, dom: 6'h01, dow: 3'h2});
		check("persisting match", 8'h00, {7'h0, alarm_flag});
		tick('{sec: 7'h31, min: 7'h12, hour: 6'h25, dom: 6'h01, dow: 3'h2});
		check("second differs", 8'h00, {7'h0, alarm_flag});
		tick('{sec: 7'h30, min: 7'h12, hour: 6'h25, dom: 6'h01, dow: 3'h2});
		check("alarm again", 8'h01, {7'h0, alarm_flag});
		clear_alarm();
		u_rtac_host.wr_reg(8'h0C, 8'h23);
		u_rtac_host.wr_reg(8'h0D, 8'h31);
		u_rtac_host.wr_reg(8'h0E, 8'h06);
		u_rtac_host.wr_reg(8'h0B, 8'h12);
		tick('{sec: 7'h30, min: 7'h12, hour: 6'h23, dom: 6'h31, dow: 3'h5});
		check("weekday differs", 8'h00, {7'h0, alarm_flag});
		tick('{sec: 7'h30, min: 7'h12, hour: 6'h23, dom: 6'h31, dow: 3'h6});
		check("full match", 8'h01, {7'h0, alarm_flag});
		wrap_up();
	end
endmodule

`default_nettype wire
